// [src/swdiag_pkg.sv]
// Shared constants and types for the switch channel diagnosis block.
package swdiag_pkg;

  // ==========================================================================
  // Channel and field layout
  localparam int NUM_CH      = 4;
  localparam int NUM_OC_CH   = 2;
  localparam int MUX_W       = 3;
  localparam int DIAG_W      = 16;
  localparam int ERR_LSB     = 0;
  localparam int SBM_BIT     = 13;
  localparam int SYDEL_W     = 2;

  // Select value that takes the sense pin off every channel.
  localparam logic [MUX_W-1:0] MUX_SENSE_OFF = 3'h7;

  // ==========================================================================
  // Reset values
  localparam logic [DIAG_W-1:0] DIAG_RESET = 16'h2000;
  localparam logic              SBM_RESET  = 1'b1;

  // ==========================================================================
  // Serial clock edge numbers within a frame
  localparam logic [1:0] EDGE_ERR_CLEAR = 2'h2;
  localparam logic [1:0] EDGE_ERR_ARM   = 2'h3;

  // ==========================================================================
  // Timing
  localparam int CLK_HZ          = 100_000_000;
  localparam int PWM_CLK_HZ      = 1_000_000;
  localparam int PWM_TICK_CYCLES = CLK_HZ / PWM_CLK_HZ;
  localparam int SYNC_PULSE_TICKS = 8;
  localparam int DLY_W           = 8;

  // Measurement delay per synchronisation delay setting, in PWM ticks.
  localparam logic [DLY_W-1:0] SYDEL_TICKS_0 = 8'h02;
  localparam logic [DLY_W-1:0] SYDEL_TICKS_1 = 8'h04;
  localparam logic [DLY_W-1:0] SYDEL_TICKS_2 = 8'h08;
  localparam logic [DLY_W-1:0] SYDEL_TICKS_3 = 8'h10;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [NUM_CH-1:0]    ot;        // Over-temperature detector.
    logic [NUM_OC_CH-1:0] oc;        // Over-current trip, channels 0 and 1.
    logic [NUM_CH-1:0]    dtl;       // Dynamic temperature retry limit hit.
    logic [NUM_CH-1:0]    dts;       // Dynamic temperature shutdown below limit.
    logic [NUM_CH-1:0]    ovl;       // Overload monitor.
    logic [NUM_CH-1:0]    vds_high;  // Bypass comparator, drain-source above threshold.
  } fault_in_type;

  typedef struct packed {
    logic [MUX_W-1:0]          sense_mux_select;
    logic                      openload_source_enable;
    logic                      openload_current_level;
    logic [1:0]                led_load_select;
    logic                      pwm_start_bit;
    logic [NUM_CH*SYDEL_W-1:0] sync_delay_field;
  } diag_cfg_type;

  typedef enum {SY_IDLE, SY_DELAY, SY_PULSE} sync_state_type;

endpackage

// [src/swdiag_sync.sv]
// Two-stage synchroniser for inputs from outside the clock domain.
`timescale 1ns/1ns
module swdiag_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,     // Sampling clock.
  input  wire logic         arst_n_i,  // Asynchronous reset, active low.
  input  wire logic [W-1:0] d_i,       // Asynchronous input.
  output logic      [W-1:0] q_o        // Synchronised output.
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // ==========================================================================
  // Stages
  // The first stage feeds only the second, so a metastable value never fans out.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule

// [src/swdiag_top.sv]
// Channel diagnosis: error flags, latches, sense routing, bypass monitor, sync pulse.
// Function
// - Error flag is overtemperature OR overload.
// - Overload latched, cleared at second SCLK edge.
// - Overtemperature latch holds channel off.
// - Channels 0,1 latch over-current off.
// - Clear-latch command alone clears latches.
// - After clear, flag re-arms after third edge.
// - First word after clear still shows failure.
// - Persistent overload re-sets flag immediately.
// - Sense off when off or faulted.
// - Dynamic shutdown clears per word; latches by command.
// - Sense only when on and fault free.
// - Mux routes channel; values 4 to 7 disable.
// - Channels 2,3 select LED or bulb ratio.
// - Open-load source on off selected channel.
// - One bit picks low or high source current.
// - Sync pulse after per-channel measurement delay.
// - Sync pulse only while PWM runs.
// - Open-load bypass zero needs selection only; source enable unused.
// - Bypass monitor flags short to battery.
// - Bypass result in control and diagnosis word.
// - Writing one clears latches; zero does nothing.
// - Error flags sit in diagnosis bits 3:0.
`timescale 1ns/1ns
module swdiag_top #(
  parameter int PWM_TICK_DIV = swdiag_pkg::PWM_TICK_CYCLES
) (
  input  wire logic                              MCLK_I,           // System clock, 100 MHz.
  input  wire logic                              ARST_N_I,         // Asynchronous reset, active low.
  input  wire logic                              SCLK_I,           // Serial clock pin.
  input  wire logic                              CS_N_I,           // Serial chip select pin, active low.
  input  wire swdiag_pkg::fault_in_type          FAULT_I,          // Analog fault detectors.
  input  wire logic [swdiag_pkg::NUM_CH-1:0]     CHAN_ON_I,        // Channel commanded on.
  input  wire logic                              CLEAR_LATCH_I,    // Clear latch bit written as one.
  input  wire swdiag_pkg::diag_cfg_type          CFG_I,            // Diagnosis configuration.
  output logic [swdiag_pkg::DIAG_W-1:0]          DIAG_WORD_O,      // Standard diagnosis word.
  output logic                                   SBM_O,            // Bypass monitor result.
  output logic [swdiag_pkg::NUM_CH-1:0]          CHAN_OFF_O,       // Latched forced switch-off.
  output logic [swdiag_pkg::NUM_CH-1:0]          SENSE_EN_O,       // Sense route to sense pin.
  output logic [1:0]                             SENSE_LED_O,      // LED ratio on channels 2,3.
  output logic [swdiag_pkg::NUM_CH-1:0]          OL_SRC_EN_O,      // Open-load source enable.
  output logic                                   OL_CUR_HIGH_O,    // Open-load high current level.
  output logic                                   SENSE_SYNC_O      // Sense sync pin.
);
  import swdiag_pkg::*;

  // ==========================================================================
  // Input synchronisation
  localparam int SYNC_W = $bits(fault_in_type) + 2;

  logic [SYNC_W-1:0] sync_out;
  fault_in_type      flt;
  logic              sclk_s;
  logic              csn_s;

  swdiag_sync #(
    .W (SYNC_W)
  ) u_sync (
    .clk_i    (MCLK_I),
    .arst_n_i (ARST_N_I),
    .d_i      ({FAULT_I, SCLK_I, !CS_N_I}),
    .q_o      (sync_out)
  );

  assign flt    = sync_out[SYNC_W-1:2];
  assign sclk_s = sync_out[1];
  // Select crosses inverted so the cleared synchroniser reads as idle; a
  // plain copy would look like a frame start on the first edge after reset.
  assign csn_s  = !sync_out[0];

  // ==========================================================================
  // Serial frame tracking
  // The serial clock is only edge-detected here, so its idle level between
  // frames does not matter; edges outside chip select are ignored.
  logic       sclk_prev_q;
  logic       csn_prev_q;
  logic [1:0] edge_cnt_q;
  logic       sclk_rise;
  logic       frame_start;
  logic       edge_clear;
  logic       edge_arm;

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      sclk_prev_q <= 1'b0;
      csn_prev_q  <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
      csn_prev_q  <= csn_s;
    end
  end

  assign sclk_rise   = sclk_s && !sclk_prev_q && !csn_s;
  assign frame_start = csn_prev_q && !csn_s;

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      edge_cnt_q <= 2'h0;
    end else if (frame_start) begin
      edge_cnt_q <= 2'h0;
    end else if (sclk_rise && edge_cnt_q != EDGE_ERR_ARM) begin
      edge_cnt_q <= edge_cnt_q + 2'h1;
    end
  end

  assign edge_clear = sclk_rise && (edge_cnt_q + 2'h1 == EDGE_ERR_CLEAR);
  assign edge_arm   = sclk_rise && (edge_cnt_q + 2'h1 == EDGE_ERR_ARM);

  // ==========================================================================
  // Gate control latches
  logic [NUM_CH-1:0] ot_latch_q;
  logic [NUM_CH-1:0] oc_latch_q;
  logic [NUM_CH-1:0] dtl_latch_q;
  logic [NUM_CH-1:0] oc_ev;

  assign oc_ev = {{(NUM_CH-NUM_OC_CH){1'b0}}, flt.oc};

  // A detector still active in the clear cycle keeps its latch set.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ot_latch_q  <= '0;
      oc_latch_q  <= '0;
      dtl_latch_q <= '0;
    end else if (CLEAR_LATCH_I) begin
      ot_latch_q  <= flt.ot;
      oc_latch_q  <= oc_ev;
      dtl_latch_q <= flt.dtl;
    end else begin
      ot_latch_q  <= ot_latch_q | flt.ot;
      oc_latch_q  <= oc_latch_q | oc_ev;
      dtl_latch_q <= dtl_latch_q | flt.dtl;
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      CHAN_OFF_O <= '0;
    end else begin
      CHAN_OFF_O <= ot_latch_q | oc_latch_q | dtl_latch_q | flt.ot | oc_ev;
    end
  end

  // ==========================================================================
  // Error flags
  // The latched faults are held a second time in the flags, so the word sent
  // right after a clear command still names the channels that had failed.
  logic              cl_pend_q;
  logic              arm_block_q;
  logic [NUM_CH-1:0] err_q;
  logic [NUM_CH-1:0] err_set;

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      cl_pend_q <= 1'b0;
    end else if (CLEAR_LATCH_I) begin
      cl_pend_q <= 1'b1;
    end else if (frame_start) begin
      cl_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      arm_block_q <= 1'b0;
    end else if (frame_start) begin
      arm_block_q <= cl_pend_q;
    end else if (edge_arm) begin
      arm_block_q <= 1'b0;
    end
  end

  // Monitor sources always set; latch sources wait for the re-arm edge.
  assign err_set = flt.ovl | flt.dts
                 | ({NUM_CH{!arm_block_q}} & (ot_latch_q | oc_latch_q | dtl_latch_q));

  // Set wins over the clear at the second serial edge.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      err_q <= '0;
    end else begin
      err_q <= (err_q & ~{NUM_CH{edge_clear}}) | err_set;
    end
  end

  // ==========================================================================
  // Sense multiplexer, bypass monitor and open-load source
  logic              sel_valid;
  logic [NUM_CH-1:0] sel_hot;
  logic [NUM_CH-1:0] fail;
  logic              sbm_d;

  assign sel_valid = CFG_I.sense_mux_select < MUX_W'(NUM_CH);

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_sel
      assign sel_hot[g] = CFG_I.sense_mux_select == MUX_W'(g);
    end
  endgenerate

  assign fail = ot_latch_q | oc_latch_q | dtl_latch_q | flt.dts | oc_ev | flt.ovl;

  // A high drain-source voltage means the output is pulled apart from the
  // battery; a low one flags a bypass when the selected channel is checked.
  assign sbm_d = sel_valid ? flt.vds_high[CFG_I.sense_mux_select[1:0]] : SBM_RESET;

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      SBM_O       <= SBM_RESET;
      DIAG_WORD_O <= DIAG_RESET;
    end else begin
      SBM_O <= sbm_d;
      DIAG_WORD_O <= '0;
      DIAG_WORD_O[SBM_BIT] <= sbm_d;
      DIAG_WORD_O[ERR_LSB +: NUM_CH] <= err_q;
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      SENSE_EN_O <= '0;
    end else begin
      SENSE_EN_O <= sel_hot & CHAN_ON_I & ~fail;
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      OL_SRC_EN_O   <= '0;
      OL_CUR_HIGH_O <= 1'b0;
      SENSE_LED_O   <= 2'h0;
    end else begin
      OL_SRC_EN_O   <= sel_hot & ~CHAN_ON_I & {NUM_CH{CFG_I.openload_source_enable}};
      OL_CUR_HIGH_O <= CFG_I.openload_current_level;
      SENSE_LED_O   <= CFG_I.led_load_select;
    end
  end

  // ==========================================================================
  // PWM tick divider
  localparam int TICK_W = $clog2(PWM_TICK_DIV + 1);

  logic [TICK_W-1:0] tick_cnt_q;
  logic              tick_q;

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == TICK_W'(PWM_TICK_DIV - 1)) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + TICK_W'(1);
      tick_q     <= 1'b0;
    end
  end

  // ==========================================================================
  // Sense synchronisation pulse
  function automatic logic [DLY_W-1:0] sydel_ticks(input logic [SYDEL_W-1:0] code);
    logic [DLY_W-1:0] t;
    case (code)
      2'h0:    t = SYDEL_TICKS_0;
      2'h1:    t = SYDEL_TICKS_1;
      2'h2:    t = SYDEL_TICKS_2;
      default: t = SYDEL_TICKS_3;
    endcase
    return t;
  endfunction

  sync_state_type    sy_state_q;
  logic [DLY_W-1:0]  sy_cnt_q;
  logic [NUM_CH-1:0] on_prev_q;
  logic              act;
  logic [1:0]        sel_ch;

  assign sel_ch = CFG_I.sense_mux_select[1:0];
  assign act    = sel_valid && CHAN_ON_I[sel_ch] && !on_prev_q[sel_ch];

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      on_prev_q <= '0;
    end else begin
      on_prev_q <= CHAN_ON_I;
    end
  end

  // Only the selected channel is timed; a new activation during a pending
  // delay restarts it, since the earlier measurement window is lost anyway.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      sy_state_q   <= SY_IDLE;
      sy_cnt_q     <= '0;
      SENSE_SYNC_O <= 1'b0;
    end else if (!CFG_I.pwm_start_bit) begin
      sy_state_q   <= SY_IDLE;
      sy_cnt_q     <= '0;
      SENSE_SYNC_O <= 1'b0;
    end else begin
      case (sy_state_q)
        SY_IDLE: begin
          SENSE_SYNC_O <= 1'b0;
          if (act) begin
            sy_state_q <= SY_DELAY;
            sy_cnt_q   <= sydel_ticks(CFG_I.sync_delay_field[sel_ch*SYDEL_W +: SYDEL_W]);
          end
        end
        SY_DELAY: begin
          if (act) begin
            sy_cnt_q <= sydel_ticks(CFG_I.sync_delay_field[sel_ch*SYDEL_W +: SYDEL_W]);
          end else if (tick_q) begin
            if (sy_cnt_q <= DLY_W'(1)) begin
              sy_state_q   <= SY_PULSE;
              sy_cnt_q     <= DLY_W'(SYNC_PULSE_TICKS);
              SENSE_SYNC_O <= 1'b1;
            end else begin
              sy_cnt_q <= sy_cnt_q - DLY_W'(1);
            end
          end
        end
        SY_PULSE: begin
          if (tick_q) begin
            if (sy_cnt_q <= DLY_W'(1)) begin
              sy_state_q   <= SY_IDLE;
              sy_cnt_q     <= '0;
              SENSE_SYNC_O <= 1'b0;
            end else begin
              sy_cnt_q <= sy_cnt_q - DLY_W'(1);
            end
          end
        end
        default: begin
          sy_state_q   <= SY_IDLE;
          SENSE_SYNC_O <= 1'b0;
        end
      endcase
    end
  end

endmodule

// [testbench/swdiag_monitor.sv]
// Concurrent checks on the ports of the channel diagnosis block.
`timescale 1ns/1ns
module swdiag_monitor #(
  parameter int PWM_TICK_DIV = 4
) (
  input wire logic                     MCLK_I,         // Clock.
  input wire logic                     ARST_N_I,       // Reset, active low.
  input wire swdiag_pkg::fault_in_type FAULT_I,        // Fault detectors.
  input wire logic [3:0]               CHAN_ON_I,      // Channel on.
  input wire logic                     CLEAR_LATCH_I,  // Clear pulse.
  input wire swdiag_pkg::diag_cfg_type CFG_I,          // Configuration.
  input wire logic [15:0]              DIAG_WORD_O,    // Diagnosis word.
  input wire logic                     SBM_O,          // Bypass result.
  input wire logic [3:0]               CHAN_OFF_O,     // Forced off.
  input wire logic [3:0]               SENSE_EN_O,     // Sense route.
  input wire logic [1:0]               SENSE_LED_O,    // LED ratio.
  input wire logic [3:0]               OL_SRC_EN_O,    // Open-load source.
  input wire logic                     OL_CUR_HIGH_O,  // Source level.
  input wire logic                     SENSE_SYNC_O    // Sync pin.
);
  import swdiag_pkg::*;
  localparam int PULSE_CYC = SYNC_PULSE_TICKS * PWM_TICK_DIV;
  int unsigned hi_cnt_q;

  // ==========================================================================
  // Sync pulse length counter
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      hi_cnt_q <= 0;
    end else begin
      hi_cnt_q <= SENSE_SYNC_O ? hi_cnt_q + 1 : 0;
    end
  end

  // ==========================================================================
  // Properties
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!ARST_N_I);

  AST_WORD_RSV: assert property ((DIAG_WORD_O & 16'hDFF0) == 16'h0000)
    else $error("reserved diagnosis bits set");
  AST_ERR_SET: assert property (FAULT_I.ovl[1] [*6] |=> DIAG_WORD_O[1])
    else $error("overload not flagged");
  AST_OFF_SET: assert property ((FAULT_I.ot[0] || FAULT_I.oc[0]) [*4] |=> CHAN_OFF_O[0])
    else $error("channel not forced off");
  AST_OFF_HOLD: assert property (!CLEAR_LATCH_I && !$past(CLEAR_LATCH_I)
    |=> (CHAN_OFF_O & $past(CHAN_OFF_O)) == $past(CHAN_OFF_O)) else $error("latch dropped without clear");
  AST_CLR_FREE: assert property ((!FAULT_I.ot[2] && !FAULT_I.dtl[2]) [*3] ##0 CLEAR_LATCH_I
    |-> ##[1:2] !CHAN_OFF_O[2]) else $error("clear did not free channel");
  AST_SENSE: assert property (SENSE_EN_O != 4'h0 |-> SENSE_EN_O == (4'h1 << $past(CFG_I.sense_mux_select))
    && (SENSE_EN_O & $past(CHAN_ON_I)) == SENSE_EN_O) else $error("bad sense route");
  AST_OL_SRC: assert property (OL_SRC_EN_O != 4'h0 |-> $past(CFG_I.openload_source_enable)
    && OL_SRC_EN_O == (4'h1 << $past(CFG_I.sense_mux_select)) && (OL_SRC_EN_O & $past(CHAN_ON_I)) == 4'h0)
    else $error("bad open-load source");
  AST_COPY: assert property (1'b1 |=> OL_CUR_HIGH_O == $past(CFG_I.openload_current_level)
    && SENSE_LED_O == $past(CFG_I.led_load_select)) else $error("config copy wrong");
  AST_SBM_OFF: assert property (CFG_I.sense_mux_select >= 3'h4 |=> SBM_O)
    else $error("bypass result not idle");
  AST_SYNC_IDLE: assert property (!CFG_I.pwm_start_bit |=> !SENSE_SYNC_O)
    else $error("sync without pwm");
  AST_SYNC_LEN: assert property (SENSE_SYNC_O |-> hi_cnt_q < PULSE_CYC)
    else $error("sync pulse too long");
endmodule

bind swdiag_top swdiag_monitor #(.PWM_TICK_DIV(PWM_TICK_DIV)) mon_u (.*);

// [testbench/swdiag_spi_host.sv]
// Behavioural serial host that frames each diagnosis transmission.
`timescale 1ns/1ns
module swdiag_spi_host (
  output logic sclk_o,  // Serial clock, idle low.
  output logic cs_n_o   // Chip select, active low.
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
  end

  // The clock stands still outside frames; the gap keeps select high well past three system clocks.
  task automatic frame(input int rises);
    cs_n_o = 1'b0;
    #125;
    repeat (rises) begin
      #63 sclk_o = 1'b1;
      #62 sclk_o = 1'b0;
    end
    #125;
    cs_n_o = 1'b1;
    #125;
  endtask
endmodule

// [testbench/switch_channel_diagnosis_tb.sv]
// Self-checking bench for the channel diagnosis block.
`timescale 1ns/1ns
module switch_channel_diagnosis_tb;
  import swdiag_pkg::*;
  localparam int DIV = 4;
  logic         mclk = 1'b0;
  logic         arst_n = 1'b0;
  logic         sclk;
  logic         cs_n;
  fault_in_type fault = '0;
  logic [3:0]   chan_on = 4'h0;
  logic         clr = 1'b0;
  diag_cfg_type cfg = 16'hE000;
  logic [15:0]  diag;
  logic [3:0]   off, sense, ol, sel;
  logic [1:0]   led;
  logic         sbm, cur, sync;
  logic         look = 1'b0;
  logic [63:0]  exp_q[$];
  logic [63:0]  e_cur;
  logic [31:0]  rnd = 32'h1E169D05;
  int           err_total = 0;
  int           comparisons = 0;
  int           d, w;
  wire  [31:0]  obs = {diag, off, sense, ol, led, cur, sbm};

  always #5 mclk = ~mclk;

  swdiag_top #(.PWM_TICK_DIV(DIV)) dut_u (
    .MCLK_I(mclk), .ARST_N_I(arst_n), .SCLK_I(sclk), .CS_N_I(cs_n), .FAULT_I(fault),
    .CHAN_ON_I(chan_on), .CLEAR_LATCH_I(clr), .CFG_I(cfg), .DIAG_WORD_O(diag), .SBM_O(sbm),
    .CHAN_OFF_O(off), .SENSE_EN_O(sense), .SENSE_LED_O(led), .OL_SRC_EN_O(ol),
    .OL_CUR_HIGH_O(cur), .SENSE_SYNC_O(sync));
  swdiag_spi_host host_u (.sclk_o(sclk), .cs_n_o(cs_n));

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] vec(input logic [3:0] e, o, s, l, input logic b);
    return {2'b00, b, 9'h000, e, o, s, l, cfg.led_load_select, cfg.openload_current_level, b};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      err_total++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Called at a falling edge; the watcher samples at the next rising edge.
  task automatic expect_obs(input logic [31:0] want, input logic [31:0] mask = 32'hFFFFFFFF);
    exp_q.push_back({mask, want & mask});
    look = 1'b1;
    @(negedge mclk);
    look = 1'b0;
  endtask
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    if (look) begin
      e_cur = exp_q.pop_front();
      check(obs & e_cur[63:32], e_cur[31:0]);
    end
  end

  initial begin
    #400000;
    err_total++;
    stop_test();
  end

  // ==========================================================================
  // Scenarios
  initial begin
    ticks(12);
    expect_obs(vec(4'h0, 4'h0, 4'h0, 4'h0, 1'b1));
    arst_n = 1'b1;
    ticks(4);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      cfg = {i[2:0], rnd[12:0] & 13'h1E00};
      chan_on = rnd[19:16];
      fault.vds_high = rnd[23:20];
      sel = (i < 4) ? 4'h1 << i : 4'h0;
      ticks(6);
      expect_obs(vec(4'h0, 4'h0, sel & chan_on, sel & ~chan_on & {4{cfg.openload_source_enable}},
                     (i < 4) ? |(sel & fault.vds_high) : 1'b1));
    end
    cfg = 16'h2000;
    chan_on = 4'hF;
    fault.vds_high = 4'h0;
    fault.ovl[1] = 1'b1;
    ticks(8);
    expect_obs(vec(4'h2, 4'h0, 4'h0, 4'h0, 1'b0));
    fault.ovl[1] = 1'b0;
    ticks(8);
    expect_obs(vec(4'h2, 4'h0, 4'h2, 4'h0, 1'b0));
    host_u.frame(3);
    ticks(4);
    expect_obs(vec(4'h0, 4'h0, 4'h2, 4'h0, 1'b0));
    fault.ovl[1] = 1'b1;
    ticks(8);
    host_u.frame(3);
    ticks(2);
    expect_obs(vec(4'h2, 4'h0, 4'h0, 4'h0, 1'b0));
    fault.ovl[1] = 1'b0;
    cfg = 16'h4000;
    fault.ot[2] = 1'b1;
    ticks(6);
    fault.ot[2] = 1'b0;
    ticks(6);
    host_u.frame(3);
    ticks(4);
    expect_obs(vec(4'h4, 4'h4, 4'h0, 4'h0, 1'b0));
    clr = 1'b1;
    ticks(1);
    clr = 1'b0;
    ticks(4);
    expect_obs(vec(4'h4, 4'h0, 4'h4, 4'h0, 1'b0));
    host_u.frame(3);
    ticks(4);
    expect_obs(vec(4'h0, 4'h0, 4'h4, 4'h0, 1'b0));
    fault.oc[0] = 1'b1;
    fault.dtl[3] = 1'b1;
    ticks(6);
    fault.oc = 2'h0;
    fault.dtl = 4'h0;
    ticks(20);
    expect_obs(vec(4'h9, 4'h9, 4'h4, 4'h0, 1'b0));
    clr = 1'b1;
    ticks(1);
    clr = 1'b0;
    fault.dts[2] = 1'b1;
    ticks(6);
    expect_obs(vec(4'hD, 4'h0, 4'h0, 4'h0, 1'b0));
    fault.dts[2] = 1'b0;
    ticks(4);
    host_u.frame(3);
    ticks(4);
    expect_obs(vec(4'h0, 4'h0, 4'h4, 4'h0, 1'b0));
    for (int k = 0; k < 4; k++) begin
      chan_on = 4'hB;
      cfg = 16'h4100 | 16'(k << 4);
      ticks(4);
      chan_on = 4'hF;
      d = 0;
      w = 0;
      while (sync !== 1'b1 && d < 200) begin
        ticks(1);
        d++;
      end
      while (sync === 1'b1 && w < 200) begin
        ticks(1);
        w++;
      end
      check(32'(d > (int'(SYDEL_TICKS_0) << k) * DIV - DIV && d <= (int'(SYDEL_TICKS_0) << k) * DIV + DIV + 4),
            32'h1);
      check(32'(w), 32'(SYNC_PULSE_TICKS * DIV));
    end
    cfg = 16'h4000;
    chan_on = 4'hB;
    ticks(4);
    chan_on = 4'hF;
    ticks(40);
    check(32'(sync), 32'h0);
    stop_test();
  end
endmodule
